// ===== src/spc_consts.svh
// Constants for the SPI checksum and multi-function pin block
`ifndef SPC_CONSTS_SVH
`define SPC_CONSTS_SVH
`define SPC_SEED         8'h9B
`define SPC_A_GAIN       4'h0
`define SPC_A_SOFTRST    4'h1
`define SPC_A_SELPOL     4'h2
`define SPC_A_BUFFER_TIMEOUT     4'h3
`define SPC_A_ERROR      4'h4
`define SPC_A_PDATA      4'h5
`define SPC_A_DIR        4'h8
`define SPC_A_ECSEN      4'h9
`define SPC_A_CFG        4'hA
`define SPC_A_CFG2       4'hB
`define SPC_A_SFR        4'hC
`define SPC_RST_BUFFER_TIMEOUT   6'h19
`define SPC_RST_CFG2     8'h10
`define SPC_OP_WRITE     2'h1
`define SPC_OP_READ      2'h2
`define SPC_OP_DIRECT    2'h3
`define SPC_NO_PIN       3'h7
`define SPC_LAST_BIT     3'h7
`define SPC_B_TRIG       5
`define SPC_B_CHECKSUM_ERROR_FLAG     7
`define SPC_B_IAR        6
`define SPC_B_ICA        4
`define SPC_B_OUT        2
`define SPC_B_GAIN       1
`define SPC_B_IOV        0
`define SPC_B_CHKEN      0
`define SPC_B_SWRST      0
`define SPC_B_POL        5
`define SPC_B_OSC        7
`define SPC_B_SYNC       6
`define SPC_P_ERR        3
`define SPC_P_TRIG       4
`define SPC_P_BUFFER_ACTIVE       5
`define SPC_CLK_MHZ      100
`define SPC_BUF_TICK_NS  240
`define SPC_FLAG_TICK_NS 1000
`endif

// ===== src/spc_pkg.sv
// Types shared by the SPI checksum and multi-function pin block
package spc_pkg;
   typedef struct packed {
      logic input_range_error;
      logic input_clamp_error;
      logic output_error;
      logic gain_error;
      logic input_overvoltage_error;
   } spc_err_in_t;

   typedef struct packed {
      logic [6:0] level;
      logic [6:0] oe_n;
   } spc_pins_t;

   typedef enum logic [1:0] {
      BUF_IDLE = 2'b00,
      BUF_WAIT = 2'b01,
      BUF_RUN  = 2'b11
   } spc_buf_st_t;
endpackage

// ===== src/spc_spi_pins.sv
// SPI command slave with checksum, multi-function pin routing and buffer timing
// Operation
// - With checksum on, writes decode only after the 24th falling SCLK edge.
// - Serial input logic samples and advances on falling SCLK edges; data out changes on rising edges.
// - Seven multi-function pins act as general I/O via data and direction.
// - Select polarity bit 1: negative SCLK edge follows select; 0: positive edge.
// - Multiplexer function drives pins 0 to 2 from gain register address bits.
// - Pin 3 error flag is the OR of the five error bits.
// - Pin 4 rise starts buffer 3-4 clocks later; held while high plus flag time.
// - Pin 5 shows buffer active, polarity chosen by configuration bit 5.
// - Special bit 7 routes oscillator to pin 6; bit 6 takes external clock.
// - Special function beats chip select, chip select beats general I/O.
// - Direction bits 0-6 map to pins 0-6; 1 output, 0 input.
// - Extended chip select needs both its enable bit and direction bit set.
// - Forced data 1 drives low, 0 high; data held under special functions.
// - Wrong write checksum discards the write and sets the checksum error flag.
// - Reads return data then checksum when 16 clocks follow the command; 24 with checksum on.
// - Checksum is 8-bit sum seeded 0x9B over command and data bytes.
// - Direct select command checksum is seed plus command byte only.
// - Chained commands accumulate one checksum over the whole select period.
// - Write with trigger starts buffer at last edge; times out after select rises.
// - Multiplexer pins follow the gain register only after select rises.
// - While extended select is active the device ignores SCLK and floats data out.
// - Write frame is 01T0 plus address nibble, then one data byte.
`timescale 1ns/1ps
`include "spc_consts.svh"
module spc_spi_pins
   import spc_pkg::*;
#(
   parameter int BUF_TICK_CYCLES  = (`SPC_BUF_TICK_NS * `SPC_CLK_MHZ) / 1000,
   parameter int FLAG_TICK_CYCLES = (`SPC_FLAG_TICK_NS * `SPC_CLK_MHZ) / 1000
)(
   input  wire logic        clk_i,
   input  wire logic        reset_i,
   input  wire logic        sclk_i,
   input  wire logic        cs_n_i,
   input  wire logic        sdi_i,
   output logic             sdo_o,
   output logic             sdo_oe_n_o,
   input  wire logic [6:0]  pin_i,
   output spc_pins_t        pins_o,
   input  wire spc_err_in_t err_i,
   output logic [4:0]       gain_o,
   output logic             buffer_active_o,
   output logic             external_clock_input_select_o
);
   // Register file, clk_i domain
   logic [2:0]  mux_addr;
   logic [6:0]  select_edge_polarity, pdata, dir, ecs_en;
   logic [5:0]  buffer_timeout;
   logic [7:0]  cfg, cfg2, sfr, err_q;
   logic        soft_rst, osc_div, trig_prev, gp_act;
   logic [6:0]  pin_s1, pin_s2, eneg_s1, eneg_s2, epos_s1, epos_s2, ecs_act;
   logic [2:0]  wr_s, err_s;
   logic        cs_s1, cs_s2;
   logic [2:0]  mux_shadow;
   logic [15:0] buf_cnt, gp_cnt;
   spc_buf_st_t buf_st;
   // Serial side, sclk_i domain
   logic [2:0]  bit_cnt;
   logic [1:0]  byte_idx;
   logic [7:0]  shift_in, cmd, wdata, sum, tx_byte, wr_data;
   logic        tx_en, handed_off, wr_tog, err_tog, wr_trig;
   logic [3:0]  wr_addr;
   logic [6:0]  ecs_neg, ecs_pos;

   function automatic logic [7:0] chk_add(input logic [7:0] a, input logic [7:0] b);
      chk_add = 8'(a + b); // carry dropped, modulo 256
   endfunction

   function automatic logic [6:0] pin_onehot(input logic [2:0] p);
      pin_onehot = 7'(8'h01 << p);
   endfunction

   wire       ef       = |{err_q[`SPC_B_IAR], err_q[`SPC_B_ICA], err_q[`SPC_B_OUT:`SPC_B_IOV]};
   wire [7:0] err_view = {err_q[7:6], buffer_active_o, err_q[4], ef, err_q[2:0]};
   wire [6:0] gpio_view = (dir & pdata) | (~dir & ~pin_s2);

   // Register read-back; settings are quasi-static across the crossing
   function automatic logic [7:0] reg_view(input logic [3:0] a);
      case (a)
         `SPC_A_GAIN:   reg_view = {gain_o, mux_addr};
         `SPC_A_SELPOL: reg_view = {1'b0, select_edge_polarity};
         `SPC_A_BUFFER_TIMEOUT: reg_view = {2'b00, buffer_timeout};
         `SPC_A_ERROR:  reg_view = err_view;
         `SPC_A_PDATA:  reg_view = {1'b0, gpio_view};
         `SPC_A_DIR:    reg_view = {1'b0, dir};
         `SPC_A_ECSEN:  reg_view = {1'b0, ecs_en};
         `SPC_A_CFG:    reg_view = cfg;
         `SPC_A_CFG2:   reg_view = cfg2;
         `SPC_A_SFR:    reg_view = sfr;
         default:       reg_view = 8'h00;
      endcase
   endfunction

   wire [7:0] rx       = {shift_in[6:0], sdi_i};
   wire       chk_mode = cfg2[`SPC_B_CHKEN];
   wire [1:0] op       = cmd[7:6];
   wire       sum_ok   = (rx == sum);
   wire       byte_end = !cs_n_i && !handed_off && (bit_cnt == `SPC_LAST_BIT);
   wire       fire_wr  = (op == `SPC_OP_WRITE) &&
                         ((byte_idx == 2'h1 && !chk_mode) || (byte_idx == 2'h2 && chk_mode && sum_ok));
   wire       fire_err = chk_mode && !sum_ok &&
                         ((op == `SPC_OP_WRITE && byte_idx == 2'h2) ||
                          ((op == `SPC_OP_READ || op == `SPC_OP_DIRECT) && byte_idx == 2'h1));
   wire [2:0] dpin     = (byte_idx == 2'h0) ? rx[2:0] : cmd[2:0];
   wire       dpin_ok  = (dpin != `SPC_NO_PIN) && ecs_en[dpin] && dir[dpin];

   // Frame state; select high clears it, SCLK may stop between frames
   always_ff @(negedge sclk_i or posedge cs_n_i) begin
      if (cs_n_i) begin
         bit_cnt    <= 3'h0;
         byte_idx   <= 2'h0;
         shift_in   <= 8'h00;
         cmd        <= 8'h00;
         wdata      <= 8'h00;
         sum        <= `SPC_SEED;
         tx_byte    <= 8'h00;
         tx_en      <= 1'b0;
         handed_off <= 1'b0;
         ecs_neg    <= 7'h00;
      end else if (!handed_off) begin
         bit_cnt  <= 3'(bit_cnt + 3'h1);
         shift_in <= rx;
         if (bit_cnt == `SPC_LAST_BIT) begin
            byte_idx <= 2'(byte_idx + 2'h1);
            tx_en    <= 1'b0;
            case (byte_idx)
               2'h0: begin
                  cmd <= rx;
                  sum <= chk_add(sum, rx);
                  if (rx[7:6] == `SPC_OP_READ && !chk_mode) begin
                     tx_byte <= reg_view(rx[3:0]);
                     tx_en   <= 1'b1;
                  end
                  if (rx[7:6] == `SPC_OP_DIRECT && !chk_mode && dpin_ok) begin
                     ecs_neg    <= pin_onehot(dpin);
                     handed_off <= 1'b1;
                  end
               end
               2'h1: begin
                  case (op)
                     `SPC_OP_WRITE: begin
                        wdata <= rx;
                        sum   <= chk_add(sum, rx);
                     end
                     `SPC_OP_READ: begin
                        tx_en <= 1'b1;
                        if (chk_mode) begin
                           tx_byte <= reg_view(cmd[3:0]);
                        end else begin
                           sum     <= chk_add(sum, tx_byte);
                           tx_byte <= chk_add(sum, tx_byte);
                        end
                     end
                     `SPC_OP_DIRECT: begin
                        byte_idx <= 2'h0;
                        if (sum_ok && dpin_ok) begin
                           ecs_neg    <= pin_onehot(dpin);
                           handed_off <= 1'b1;
                        end
                     end
                     default: ;
                  endcase
               end
               2'h2: begin
                  if (op == `SPC_OP_READ && chk_mode) begin
                     sum     <= chk_add(sum, tx_byte);
                     tx_byte <= chk_add(sum, tx_byte);
                     tx_en   <= 1'b1;
                  end else begin
                     byte_idx <= 2'h0;
                  end
               end
               default: byte_idx <= 2'h0;
            endcase
         end
      end
   end

   // Events to clk_i; not cleared by select so a late crossing still sees them
   always_ff @(negedge sclk_i or posedge reset_i) begin
      if (reset_i) begin
         wr_tog  <= 1'b0;
         err_tog <= 1'b0;
         wr_addr <= 4'h0;
         wr_data <= 8'h00;
         wr_trig <= 1'b0;
      end else if (byte_end) begin
         if (fire_wr) begin
            wr_tog  <= ~wr_tog;
            wr_addr <= cmd[3:0];
            wr_data <= chk_mode ? wdata : rx;
            wr_trig <= cmd[`SPC_B_TRIG];
         end
         if (fire_err) begin
            err_tog <= ~err_tog; // bad write never toggles wr_tog
         end
      end
   end

   // Data out changes on rising SCLK, floats once handed off
   always_ff @(posedge sclk_i or posedge cs_n_i) begin
      if (cs_n_i) begin
         sdo_o      <= 1'b0;
         sdo_oe_n_o <= 1'b1;
         ecs_pos    <= 7'h00;
      end else begin
         sdo_o      <= tx_byte[3'(`SPC_LAST_BIT - bit_cnt)];
         sdo_oe_n_o <= !(tx_en && !handed_off);
         ecs_pos    <= ecs_neg;
      end
   end

   // Synchronisers into clk_i
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         {pin_s1, pin_s2, eneg_s1, eneg_s2, epos_s1, epos_s2} <= '0;
         wr_s  <= 3'h0;
         err_s <= 3'h0;
         cs_s1 <= 1'b1;
         cs_s2 <= 1'b1;
      end else begin
         pin_s1  <= pin_i;
         pin_s2  <= pin_s1;
         eneg_s1 <= ecs_neg;
         eneg_s2 <= eneg_s1;
         epos_s1 <= ecs_pos;
         epos_s2 <= epos_s1;
         wr_s    <= {wr_s[1:0], wr_tog};
         err_s   <= {err_s[1:0], err_tog};
         cs_s1   <= cs_n_i;
         cs_s2   <= cs_s1;
      end
   end

   wire wr_ev  = wr_s[2] ^ wr_s[1];
   wire chk_ev = err_s[2] ^ err_s[1];
   wire sw_trig = wr_ev && wr_trig;
   wire trig_rise = sfr[`SPC_P_TRIG] && pin_s2[`SPC_P_TRIG] && !trig_prev;

   // Per-pin edge choice of the extended select
   always_comb begin
      ecs_act = (select_edge_polarity & eneg_s2) | (~select_edge_polarity & epos_s2);
   end

   // Configuration registers; soft reset restores defaults
   always_ff @(posedge clk_i) begin
      if (reset_i || soft_rst) begin
         {gain_o, mux_addr}   <= 8'h00;
         select_edge_polarity <= 7'h00;
         buffer_timeout       <= `SPC_RST_BUFFER_TIMEOUT;
         {pdata, dir, ecs_en} <= '0;
         cfg                  <= 8'h00;
         cfg2                 <= `SPC_RST_CFG2;
         sfr                  <= 8'h00;
      end else if (wr_ev) begin
         case (wr_addr)
            `SPC_A_GAIN:   {gain_o, mux_addr} <= wr_data;
            `SPC_A_SELPOL: select_edge_polarity <= wr_data[6:0];
            `SPC_A_BUFFER_TIMEOUT: buffer_timeout <= wr_data[5:0];
            `SPC_A_PDATA:  pdata <= wr_data[6:0]; // held under special use
            `SPC_A_DIR:    dir <= wr_data[6:0];
            `SPC_A_ECSEN:  ecs_en <= wr_data[6:0];
            `SPC_A_CFG:    cfg <= wr_data;
            `SPC_A_CFG2:   cfg2 <= wr_data;
            `SPC_A_SFR:    sfr <= wr_data;
            default: ;
         endcase
      end
   end

   // Soft reset pulse and clock select copy
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         soft_rst                      <= 1'b0;
         external_clock_input_select_o <= 1'b0;
         osc_div                       <= 1'b0;
      end else begin
         soft_rst <= wr_ev && (wr_addr == `SPC_A_SOFTRST) && wr_data[`SPC_B_SWRST];
         external_clock_input_select_o <= sfr[`SPC_B_SYNC];
         osc_div  <= ~osc_div;
      end
   end

   // Sticky error bits, set beats write-one clear
   always_ff @(posedge clk_i) begin
      if (reset_i || soft_rst) begin
         err_q <= 8'h00;
      end else begin
         err_q <= (err_q & ~((wr_ev && wr_addr == `SPC_A_ERROR) ? wr_data : 8'h00)) |
                  {chk_ev,
                   err_i.input_range_error && !cfg[`SPC_B_IAR], 1'b0,
                   err_i.input_clamp_error && !cfg[`SPC_B_ICA], 1'b0,
                   err_i.output_error && !cfg[`SPC_B_OUT],
                   err_i.gain_error && !cfg[`SPC_B_GAIN],
                   err_i.input_overvoltage_error && !cfg[`SPC_B_IOV]};
      end
   end

   // Multiplexer address moves only while select is high
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         mux_shadow <= 3'h0;
      end else if (cs_s2) begin
         mux_shadow <= mux_addr;
      end
   end

   // Software buffer: armed by trigger write, timed from select rise
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         buf_st  <= BUF_IDLE;
         buf_cnt <= 16'h0000;
      end else begin
         case (buf_st)
            BUF_IDLE: if (sw_trig) buf_st <= BUF_WAIT;
            BUF_WAIT: begin
               if (cs_s2) begin
                  buf_st  <= BUF_RUN;
                  buf_cnt <= 16'(buffer_timeout * BUF_TICK_CYCLES);
               end
            end
            BUF_RUN: begin
               if (sw_trig) buf_st <= BUF_WAIT;
               else if (buf_cnt == 16'h0000) buf_st <= BUF_IDLE;
               else buf_cnt <= 16'(buf_cnt - 16'h0001);
            end
            default: buf_st <= BUF_IDLE;
         endcase
      end
   end

   // Pin trigger; the two-stage sync gives the 3-4 clock start and stop lag
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         trig_prev <= 1'b0;
         gp_act    <= 1'b0;
         gp_cnt    <= 16'h0000;
      end else begin
         trig_prev <= pin_s2[`SPC_P_TRIG];
         if (trig_rise || (gp_act && pin_s2[`SPC_P_TRIG])) begin
            gp_act <= 1'b1;
            gp_cnt <= 16'(cfg2[5:2] * FLAG_TICK_CYCLES);
         end else if (gp_act) begin
            if (gp_cnt == 16'h0000) gp_act <= 1'b0;
            else gp_cnt <= 16'(gp_cnt - 16'h0001);
         end
      end
   end

   // Buffer-active output
   always_ff @(posedge clk_i) begin
      if (reset_i) buffer_active_o <= 1'b0;
      else buffer_active_o <= (buf_st != BUF_IDLE) || gp_act;
   end

   // Pin drive: special beats select beats general I/O
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         pins_o.level <= 7'h00;
         pins_o.oe_n  <= 7'h7F;
      end else begin
         pins_o.oe_n <= ~dir;
         for (int i = 0; i < 7; i++) begin
            if (i == 6 && (sfr[`SPC_B_OSC] || sfr[`SPC_B_SYNC])) begin
               pins_o.level[i] <= osc_div && sfr[`SPC_B_OSC];
            end else if (i < 6 && sfr[i]) begin
               case (i)
                  `SPC_P_ERR:  pins_o.level[i] <= ef;
                  `SPC_P_TRIG: pins_o.level[i] <= 1'b0;
                  `SPC_P_BUFFER_ACTIVE: pins_o.level[i] <= buffer_active_o ^ cfg[`SPC_B_POL];
                  default:     pins_o.level[i] <= mux_shadow[i];
               endcase
            end else if (ecs_en[i] && dir[i]) begin
               pins_o.level[i] <= ~ecs_act[i];
            end else begin
               pins_o.level[i] <= ~pdata[i];
            end
         end
      end
   end

   sequence s_trig_rise;
      trig_rise;
   endsequence
   sequence s_buffer_active_up;
      ##2 buffer_active_o;
   endsequence
   property p_trig_start;
      @(posedge clk_i) disable iff (reset_i) s_trig_rise |-> s_buffer_active_up;
   endproperty
   a_trig_start: assert property (p_trig_start) else $error("pin trigger did not start buffer");
   property p_sw_buf;
      @(posedge clk_i) disable iff (reset_i) sw_trig |-> s_buffer_active_up;
   endproperty
   a_sw_buf: assert property (p_sw_buf) else $error("trigger write did not start buffer");
   property p_buf_wait;
      @(posedge clk_i) disable iff (reset_i) (buf_st == BUF_WAIT && !cs_s2) |=> buf_st == BUF_WAIT;
   endproperty
   a_buf_wait: assert property (p_buf_wait) else $error("buffer timeout began before select rose");
   property p_mux_hold;
      @(posedge clk_i) disable iff (reset_i) !cs_s2 |=> $stable(mux_shadow);
   endproperty
   a_mux_hold: assert property (p_mux_hold) else $error("mux address moved during select");
   property p_force;
      @(posedge clk_i) disable iff (reset_i) (!sfr[0] && !ecs_en[0]) |=> pins_o.level[0] == !$past(pdata[0]);
   endproperty
   a_force: assert property (p_force) else $error("forced pin level wrong");
   property p_dir;
      @(posedge clk_i) disable iff (reset_i) 1'b1 |=> pins_o.oe_n == ~$past(dir);
   endproperty
   a_dir: assert property (p_dir) else $error("pin direction wrong");
   property p_err_pin;
      @(posedge clk_i) disable iff (reset_i) sfr[`SPC_P_ERR] |=> pins_o.level[`SPC_P_ERR] == $past(ef);
   endproperty
   a_err_pin: assert property (p_err_pin) else $error("error flag pin wrong");
   property p_buffer_active_pin;
      @(posedge clk_i) disable iff (reset_i)
         sfr[`SPC_P_BUFFER_ACTIVE] |=> pins_o.level[`SPC_P_BUFFER_ACTIVE] == $past(buffer_active_o ^ cfg[`SPC_B_POL]);
   endproperty
   a_buffer_active_pin: assert property (p_buffer_active_pin) else $error("buffer active pin wrong");
   property p_ecs_pin;
      @(posedge clk_i) disable iff (reset_i) (!sfr[1] && ecs_en[1] && dir[1]) |=> pins_o.level[1] == !$past(ecs_act[1]);
   endproperty
   a_ecs_pin: assert property (p_ecs_pin) else $error("extended select pin wrong");
   property p_chk_discard;
      @(negedge sclk_i) disable iff (cs_n_i || reset_i) (byte_end && fire_err) |=> $stable(wr_tog) && $changed(err_tog);
   endproperty
   a_chk_discard: assert property (p_chk_discard) else $error("bad checksum write not discarded");
endmodule // spc_spi_pins

// ===== tb/spc_master.sv
// SPI master model for the checksum and pin block bench
`timescale 1ns/1ps
module spc_master (
   input  wire logic lclk_i,
   input  wire logic sdo_i,
   input  wire logic sdo_oe_n_i,
   output logic      sclk_o,
   output logic      cs_n_o,
   output logic      sdi_o
);
   logic line;
   // Floated data out reads as the pull-up level
   assign line = sdo_oe_n_i ? 1'b1 : sdo_i;
   // Link clock stands still high outside frames
   initial begin
      sclk_o = 1'b1;
      cs_n_o = 1'b1;
      sdi_o  = 1'b0;
   end
   // Select falls, bytes shift MSB first; select stays low if asked
   task automatic frame(input logic [7:0] tx[$], output logic [7:0] rx[$], input logic keep);
      logic [7:0] b;
      rx = {};
      @(negedge lclk_i);
      cs_n_o = 1'b0;
      foreach (tx[k]) begin
         for (int i = 7; i >= 0; i--) begin
            @(negedge lclk_i);
            sclk_o = 1'b1;
            sdi_o  = tx[k][i];
            @(posedge lclk_i);
            sclk_o = 1'b0; // Both sides sample on the fall
            b[i]   = line;
         end
         rx.push_back(b);
      end
      @(negedge lclk_i);
      sclk_o = 1'b1;
      sdi_o  = ~sdi_o; // No stale value once released
      if (!keep) release_cs();
   endtask
   // End the frame and leave a gap
   task automatic release_cs();
      @(negedge lclk_i);
      cs_n_o = 1'b1;
      repeat (2) @(negedge lclk_i);
   endtask
endmodule // spc_master

// ===== tb/tb_spi_checksum_pin_function_control.sv
// Self-checking bench for the SPI checksum and multi-function pin block
`timescale 1ns/1ps
`include "spc_consts.svh"
module tb_spi_checksum_pin_function_control;
   import spc_pkg::*;
   logic        clk_i;
   logic        reset_i;
   logic        lclk;
   logic        sclk;
   logic        cs_n;
   logic        sdi;
   logic        sdo;
   logic        sdo_oe_n;
   logic [6:0]  pin_in;
   spc_pins_t   pins;
   spc_err_in_t err_in;
   logic [4:0]  gain;
   logic        buf_act;
   logic        ext_sel;
   int          miscompares;
   int          cmp_count;
   logic [7:0]  rx[$];
   logic [7:0]  tx[$];

   // Short tick counts keep timeouts brief
   spc_spi_pins #(.BUF_TICK_CYCLES(2), .FLAG_TICK_CYCLES(2)) uut (
      .clk_i(clk_i), .reset_i(reset_i), .sclk_i(sclk), .cs_n_i(cs_n), .sdi_i(sdi), .sdo_o(sdo),
      .sdo_oe_n_o(sdo_oe_n), .pin_i(pin_in), .pins_o(pins), .err_i(err_in), .gain_o(gain),
      .buffer_active_o(buf_act), .external_clock_input_select_o(ext_sel));
   spc_master master (.lclk_i(lclk), .sdo_i(sdo), .sdo_oe_n_i(sdo_oe_n), .sclk_o(sclk),
      .cs_n_o(cs_n), .sdi_o(sdi));

   // Master clock and an unrelated 64 ns link clock
   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end
   initial begin
      lclk = 1'b0;
      #7;
      forever #32 lclk = ~lclk;
   end

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         miscompares++;
         $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask
   // Running sum, carry dropped
   function automatic logic [7:0] sum8(input logic [7:0] b[$]);
      logic [7:0] s;
      s = `SPC_SEED;
      foreach (b[i]) s += b[i];
      return s;
   endfunction
   // Optional checksum, then pad bytes that clock out the answer
   task automatic send(input logic [7:0] b[$], input logic add_chk, input int pad, input logic keep);
      if (add_chk) b.push_back(sum8(b));
      repeat (pad) b.push_back(8'h00);
      master.frame(b, rx, keep);
   endtask
   // Bounded wait on the buffer flag
   task automatic wait_buf(input logic lvl, input int n);
      int i;
      i = 0;
      while (buf_act !== lvl && i < n) begin
         @(negedge clk_i); // Settled half a cycle after launch
         i++;
      end
      check({7'h00, buf_act}, {7'h00, lvl});
   endtask
   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask

   task automatic t_read();
      check({1'h0, pins.oe_n}, 8'h7F);
      send('{8'h83}, 1'b0, 2, 1'b0);
      check(rx[1], 8'h19);
      check(rx[2], sum8('{8'h83, 8'h19}));
   endtask
   task automatic t_pins();
      send('{8'h45, 8'h01}, 1'b0, 1, 1'b0); // Data before direction
      send('{8'h48, 8'h7F}, 1'b0, 1, 1'b0);
      send('{8'h40, 8'h18}, 1'b0, 1, 1'b0);
      check({1'h0, pins.oe_n}, 8'h00);
      check({1'h0, pins.level}, 8'h7E);
      check({3'h0, gain}, 8'h03);
   endtask
   task automatic t_direct();
      send('{8'h49, 8'h02}, 1'b0, 1, 1'b0);
      send('{8'hC1}, 1'b0, 0, 1'b1);
      repeat (10) @(posedge clk_i);
      check({7'h00, pins.level[1]}, 8'h00);
      check({7'h00, sdo_oe_n}, 8'h01);
      master.release_cs();
      check({7'h00, pins.level[1]}, 8'h01);
   endtask
   task automatic t_bad_chk();
      send('{8'h4B, 8'h01}, 1'b0, 1, 1'b0);
      send('{8'h40, 8'hF8, 8'h00}, 1'b0, 1, 1'b0); // Wrong checksum, one more byte follows
      @(posedge clk_i);
      err_in.gain_error <= 1'b1;
      repeat (3) @(posedge clk_i);
      err_in.gain_error <= 1'b0;
      check({3'h0, gain}, 8'h03);
      send('{8'h84}, 1'b1, 2, 1'b0);
      check(rx[2], 8'h8A);
      check(rx[3], sum8('{8'h84, 8'h8A}));
   endtask
   task automatic t_chain();
      tx = '{8'h43, 8'h05};
      tx.push_back(sum8(tx));
      tx.push_back(8'h83);
      tx.push_back(sum8('{8'h43, 8'h05, 8'h83}));
      tx.push_back(8'h00);
      tx.push_back(8'h00);
      master.frame(tx, rx, 1'b0);
      check(rx[5], 8'h05);
      check(rx[6], sum8('{8'h43, 8'h05, 8'h83, 8'h05}));
   endtask
   task automatic t_mux();
      send('{8'h4C, 8'h47}, 1'b1, 0, 1'b0);
      send('{8'h40, 8'h1D}, 1'b1, 0, 1'b0);
      check({5'h00, pins.level[2:0]}, 8'h05); // Pin 1 beats its select
      check({3'h0, gain}, 8'h03);
      check({7'h00, ext_sel}, 8'h01);
   endtask
   task automatic t_trigger();
      send('{8'h60, 8'h1D}, 1'b1, 0, 1'b1);
      wait_buf(1'b1, 40);
      master.release_cs();
      wait_buf(1'b0, 200);
   endtask
   task automatic t_pin_trig();
      send('{8'h48, 8'h6F}, 1'b1, 0, 1'b0); // Pin 4 made an input first
      send('{8'h4A, 8'h20}, 1'b1, 0, 1'b0);
      send('{8'h4C, 8'h38}, 1'b1, 0, 1'b0);
      check({7'h00, ext_sel}, 8'h00);
      check({7'h00, pins.level[3]}, 8'h01); // Gain error still held
      check({7'h00, pins.level[5]}, 8'h01); // Inverted idle level
      @(posedge clk_i);
      pin_in[4] <= 1'b1;
      wait_buf(1'b1, 8);
      repeat (2) @(negedge clk_i);
      check({7'h00, pins.level[5]}, 8'h00);
      send('{8'h85}, 1'b1, 2, 1'b0);
      check(rx[2], 8'h01); // High input pin reads 0
      check(rx[3], sum8('{8'h85, 8'h01}));
      check({7'h00, buf_act}, 8'h01); // Held while the pin stays high
      @(posedge clk_i);
      pin_in[4] <= 1'b0;
      wait_buf(1'b0, 12);
      send('{8'hC1}, 1'b1, 0, 1'b1);
      repeat (10) @(posedge clk_i);
      check({7'h00, pins.level[1]}, 8'h00); // Direct select with checksum
      master.release_cs();
      check({7'h00, pins.level[1]}, 8'h01);
   endtask

   // Reset, then the scenarios in order
   initial begin
      reset_i = 1'b1;
      pin_in = 7'h00;
      err_in = '0;
      miscompares = 0;
      cmp_count = 0;
      repeat (10) @(posedge clk_i);
      reset_i <= 1'b0;
      repeat (4) @(posedge clk_i);
      t_read();
      t_pins();
      t_direct();
      t_bad_chk();
      t_chain();
      t_mux();
      t_trigger();
      t_pin_trig();
      report_and_stop();
   end
   // Hang guard
   initial begin
      repeat (100000) @(posedge clk_i);
      miscompares++;
      report_and_stop();
   end
endmodule // tb_spi_checksum_pin_function_control
